//--- design/ctdb_regs.sv
// Threshold DAC code registers, chain target/broadcast register and chain link command register.
`timescale 1ns/1ps
`default_nettype none
`include "ctdb_defs.svh"
module ctdb_regs (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic is_master,
    input wire logic [`CTDB_DEV_W-1:0] my_dev_addr,
    input wire ctdb_pkg::ctdb_access_t host_acc,
    output logic [`CTDB_DATA_W-1:0] host_rdata,
    input wire ctdb_pkg::ctdb_frame_t link_frame,
    output logic [`CTDB_DATA_W-1:0] link_rdata,
    output logic link_rvalid,
    input wire logic xact_done,
    output logic [`CTDB_DATA_W-1:0] target_param,
    output logic link_cmd_start,
    output logic [`CTDB_OP_W-1:0] link_cmd_op,
    output logic timer_wr,
    output logic [`CTDB_DATA_W-1:0] timer_wdata,
    output logic [`CTDB_CODE_W-1:0] ref_code,
    output logic [`CTDB_CODE_W-1:0] upper_code,
    output logic [`CTDB_CODE_W-1:0] lower_code
);
    logic [`CTDB_DATA_W-1:0] target_q;
    logic [`CTDB_DATA_W-1:0] target_d;
    logic [`CTDB_DATA_W-1:0] cmd_q;
    logic [`CTDB_DATA_W-1:0] cmd_d;
    logic [`CTDB_DATA_W-1:0] host_rdata_q;
    logic [`CTDB_DATA_W-1:0] link_rdata_q;
    logic link_rvalid_q;
    logic timer_wr_q;
    logic [`CTDB_DATA_W-1:0] timer_wdata_q;

    logic [`CTDB_CODE_W-1:0] code [`CTDB_NCH];
    logic [`CTDB_ADDR_W-1:0] ch_lo_addr [`CTDB_NCH];
    logic [`CTDB_ADDR_W-1:0] ch_hi_addr [`CTDB_NCH];
    logic [`CTDB_DEV_W-1:0] ch_bc_param [`CTDB_NCH];

    // Channel 0 reference, channel 1 upper limit, channel 2 lower limit.
    assign ch_lo_addr[0] = `CTDB_ADDR_REF_LO;
    assign ch_hi_addr[0] = `CTDB_ADDR_REF_HI;
    assign ch_bc_param[0] = `CTDB_BC_REF;
    assign ch_lo_addr[1] = `CTDB_ADDR_UPPER_LO;
    assign ch_hi_addr[1] = `CTDB_ADDR_UPPER_HI;
    assign ch_bc_param[1] = `CTDB_BC_UPPER;
    assign ch_lo_addr[2] = `CTDB_ADDR_LOWER_LO;
    assign ch_hi_addr[2] = `CTDB_ADDR_LOWER_HI;
    assign ch_bc_param[2] = `CTDB_BC_LOWER;

    // Link frame decode.
    wire frame_ok = ce && link_frame.valid;
    wire dev_hit = (link_frame.param == my_dev_addr) || (link_frame.param == `CTDB_BCAST_ADDR);
    wire single_wr = frame_ok && (link_frame.op == `CTDB_OP_SINGLE_WRITE) && dev_hit;
    wire single_rd = frame_ok && (link_frame.op == `CTDB_OP_SINGLE_READ) && dev_hit;
    wire bcast_wr = frame_ok && (link_frame.op == `CTDB_OP_BCAST_WRITE)
                    && (link_frame.param == `CTDB_BWR_PARAM);
    wire bcast_cfg = frame_ok && (link_frame.op == `CTDB_OP_BCAST_CONFIG);
    wire bcast_timer = bcast_cfg && (link_frame.param == `CTDB_BC_TIMER);
    wire link_wr = single_wr || bcast_wr;
    wire [`CTDB_ADDR_W-1:0] link_addr = {1'b0, link_frame.reg_addr};
    wire [`CTDB_DATA_W-1:0] link_byte = link_frame.data[`CTDB_DATA_W-1:0];

    // Host port decode; the host wins when both sides write the same register in one cycle.
    wire host_wr = ce && host_acc.wr;
    wire host_rd = ce && host_acc.rd;
    wire host_target_wr = host_wr && (host_acc.addr == `CTDB_ADDR_TARGET);
    wire host_cmd_wr = host_wr && (host_acc.addr == `CTDB_ADDR_LINK_CMD);

    logic [`CTDB_DATA_W-1:0] ch_lo_rd [`CTDB_NCH];
    logic [`CTDB_DATA_W-1:0] ch_hi_rd [`CTDB_NCH];
    logic [`CTDB_DATA_W-1:0] ch_host_rd [`CTDB_NCH];
    logic [`CTDB_DATA_W-1:0] ch_link_rd [`CTDB_NCH];

    genvar i;
    generate
        for (i = 0; i < `CTDB_NCH; i++)
        begin : g_ch
            wire h_lo = host_wr && (host_acc.addr == ch_lo_addr[i]);
            wire h_hi = host_wr && (host_acc.addr == ch_hi_addr[i]);
            wire l_lo = link_wr && (link_addr == ch_lo_addr[i]);
            wire l_hi = link_wr && (link_addr == ch_hi_addr[i]);
            wire load = bcast_cfg && (link_frame.param == ch_bc_param[i]);
            // Each byte picks its own source, so a host write to one byte leaves a link write to the other intact.
            wire [`CTDB_DATA_W-1:0] lo_wdata = h_lo ? host_acc.wdata : link_byte;
            wire [`CTDB_HI_W-1:0] hi_wdata = h_hi ? host_acc.wdata[`CTDB_HI_W-1:0] : link_byte[`CTDB_HI_W-1:0];

            ctdb_dac_pair u_pair (
                .clk(clk),
                .rst_n(rst_n),
                .ce(ce),
                .wr_lo(h_lo || l_lo),
                .wr_hi(h_hi || l_hi),
                .wdata(lo_wdata),
                .wdata_hi(hi_wdata),
                .load(load),
                .load_code(link_frame.data[`CTDB_CODE_W-1:0]),
                .code(code[i])
            );

            assign ch_lo_rd[i] = code[i][`CTDB_DATA_W-1:0];
            assign ch_hi_rd[i] = {{(`CTDB_DATA_W-`CTDB_HI_W){1'b0}}, code[i][`CTDB_CODE_W-1:`CTDB_DATA_W]};
            assign ch_host_rd[i] = (host_acc.addr == ch_lo_addr[i]) ? ch_lo_rd[i] :
                                   (host_acc.addr == ch_hi_addr[i]) ? ch_hi_rd[i] : `CTDB_RST_BYTE;
            assign ch_link_rd[i] = (link_addr == ch_lo_addr[i]) ? ch_lo_rd[i] :
                                   (link_addr == ch_hi_addr[i]) ? ch_hi_rd[i] : `CTDB_RST_BYTE;
        end
    endgenerate

    assign ref_code = code[0];
    assign upper_code = code[1];
    assign lower_code = code[2];

    // Read multiplexers; addresses outside this group read as zero.
    wire [`CTDB_DATA_W-1:0] dac_host_rd = ch_host_rd[0] | ch_host_rd[1] | ch_host_rd[2];
    wire [`CTDB_DATA_W-1:0] dac_link_rd = ch_link_rd[0] | ch_link_rd[1] | ch_link_rd[2];
    wire [`CTDB_DATA_W-1:0] host_rd_val = (host_acc.addr == `CTDB_ADDR_TARGET) ? target_q :
                                          (host_acc.addr == `CTDB_ADDR_LINK_CMD) ? cmd_q : dac_host_rd;
    // The link never sees the target or command registers.
    wire [`CTDB_DATA_W-1:0] link_rd_val = dac_link_rd;

    // Top two target bits are written as zero unless this device is the chain master.
    wire [`CTDB_DATA_W-1:0] target_mask = is_master ? ~`CTDB_RST_BYTE : `CTDB_TARGET_SLAVE_MASK;
    assign target_d = host_target_wr ? (host_acc.wdata & target_mask) : target_q;

    // A host write in the completion cycle wins over the clear so a new start is not lost.
    assign cmd_d = host_cmd_wr ? (host_acc.wdata & `CTDB_LINK_CMD_MASK) :
                   (ce && xact_done) ? `CTDB_RST_BYTE : cmd_q;

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            target_q <= `CTDB_RST_BYTE;
        end
        else if (ce)
        begin
            target_q <= target_d;
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cmd_q <= `CTDB_RST_BYTE;
        end
        else if (ce)
        begin
            cmd_q <= cmd_d;
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            host_rdata_q <= `CTDB_RST_BYTE;
        end
        else if (host_rd)
        begin
            host_rdata_q <= host_rd_val;
        end
    end

    // An addressed read frame is answered by a one-cycle pulse with the byte beside it.
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            link_rdata_q <= `CTDB_RST_BYTE;
            link_rvalid_q <= 1'b0;
        end
        else if (ce)
        begin
            if (single_rd)
            begin
                link_rdata_q <= link_rd_val;
            end
            link_rvalid_q <= single_rd;
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            timer_wr_q <= 1'b0;
            timer_wdata_q <= `CTDB_RST_BYTE;
        end
        else if (ce)
        begin
            timer_wr_q <= bcast_timer;
            if (bcast_timer)
            begin
                timer_wdata_q <= link_byte;
            end
        end
    end

    assign host_rdata = host_rdata_q;
    assign link_rdata = link_rdata_q;
    assign link_rvalid = link_rvalid_q;
    assign target_param = target_q;
    assign link_cmd_start = cmd_q[`CTDB_LINK_CMD_START];
    assign link_cmd_op = cmd_q[`CTDB_LINK_CMD_OP_MSB:`CTDB_LINK_CMD_OP_LSB];
    assign timer_wr = timer_wr_q;
    assign timer_wdata = timer_wdata_q;
endmodule : ctdb_regs
`default_nettype wire

//--- design/ctdb_defs.svh
// Register offsets, field positions, reset values and command codes of the threshold register group.
`ifndef CTDB_DEFS_SVH
`define CTDB_DEFS_SVH

`define CTDB_ADDR_W 8
`define CTDB_DATA_W 8
`define CTDB_CODE_W 12
`define CTDB_HI_W 4
`define CTDB_DEV_W 6
`define CTDB_REGA_W 7
`define CTDB_OP_W 3
`define CTDB_PAY_W 16
`define CTDB_NCH 3

`define CTDB_ADDR_REF_LO 8'h1f
`define CTDB_ADDR_REF_HI 8'h20
`define CTDB_ADDR_UPPER_LO 8'h21
`define CTDB_ADDR_UPPER_HI 8'h22
`define CTDB_ADDR_LOWER_LO 8'h23
`define CTDB_ADDR_LOWER_HI 8'h24
`define CTDB_ADDR_TARGET 8'h25
`define CTDB_ADDR_LINK_CMD 8'h28

`define CTDB_RST_BYTE 8'h00
`define CTDB_RST_CODE 12'h000
`define CTDB_RST_HI 4'h0
`define CTDB_HI_MASK 8'h0f
`define CTDB_TARGET_SLAVE_MASK 8'h3f
`define CTDB_LINK_CMD_MASK 8'h0f
`define CTDB_LINK_CMD_START 0
`define CTDB_LINK_CMD_OP_LSB 1
`define CTDB_LINK_CMD_OP_MSB 3

`define CTDB_OP_SINGLE_READ 3'h1
`define CTDB_OP_SINGLE_WRITE 3'h2
`define CTDB_OP_ADDR_ALLOC 3'h3
`define CTDB_OP_BCAST_CONFIG 3'h4
`define CTDB_OP_BCAST_WRITE 3'h5

`define CTDB_BCAST_ADDR 6'h00
`define CTDB_BC_NOP 6'h00
`define CTDB_BC_TIMER 6'h01
`define CTDB_BC_REF 6'h02
`define CTDB_BC_LOWER 6'h03
`define CTDB_BC_UPPER 6'h04
`define CTDB_BWR_PARAM 6'h00

`endif

//--- design/ctdb_pkg.sv
// Types shared by the threshold register group.
`include "ctdb_defs.svh"
package ctdb_pkg;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [`CTDB_ADDR_W-1:0] addr;
        logic [`CTDB_DATA_W-1:0] wdata;
    } ctdb_access_t;

    typedef struct packed {
        logic valid;
        logic [`CTDB_OP_W-1:0] op;
        logic [`CTDB_DEV_W-1:0] param;
        logic [`CTDB_REGA_W-1:0] reg_addr;
        logic [`CTDB_PAY_W-1:0] data;
    } ctdb_frame_t;

endpackage : ctdb_pkg

//--- design/ctdb_dac_pair.sv
// One 12-bit DAC code held as a low byte register and a four-bit high register.
`timescale 1ns/1ps
`default_nettype none
`include "ctdb_defs.svh"
module ctdb_dac_pair (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic wr_lo,
    input wire logic wr_hi,
    input wire logic [`CTDB_DATA_W-1:0] wdata,
    input wire logic [`CTDB_HI_W-1:0] wdata_hi,
    input wire logic load,
    input wire logic [`CTDB_CODE_W-1:0] load_code,
    output logic [`CTDB_CODE_W-1:0] code
);
    logic [`CTDB_DATA_W-1:0] lo_q;
    logic [`CTDB_DATA_W-1:0] lo_d;
    logic [`CTDB_HI_W-1:0] hi_q;
    logic [`CTDB_HI_W-1:0] hi_d;

    // A byte write lands after a whole-code load in the same cycle, so the byte write wins.
    assign lo_d = wr_lo ? wdata : (load ? load_code[`CTDB_DATA_W-1:0] : lo_q);
    assign hi_d = wr_hi ? wdata_hi : (load ? load_code[`CTDB_CODE_W-1:`CTDB_DATA_W] : hi_q);

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            lo_q <= `CTDB_RST_BYTE;
            hi_q <= `CTDB_RST_HI;
        end
        else if (ce)
        begin
            lo_q <= lo_d;
            hi_q <= hi_d;
        end
    end

    assign code = {hi_q, lo_q};
endmodule : ctdb_dac_pair
`default_nettype wire

//--- test/ctdb_regs_chk.sv
// Concurrent checks on the ports of the threshold register group.
`timescale 1ns/1ps
`default_nettype none
module ctdb_regs_chk (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic is_master,
    input wire logic [5:0] my_dev_addr,
    input wire ctdb_pkg::ctdb_access_t host_acc,
    input wire ctdb_pkg::ctdb_frame_t link_frame,
    input wire logic xact_done,
    input wire logic [7:0] target_param,
    input wire logic link_cmd_start,
    input wire logic [2:0] link_cmd_op,
    input wire logic link_rvalid,
    input wire logic timer_wr,
    input wire logic [7:0] timer_wdata,
    input wire logic [11:0] ref_code,
    input wire logic [11:0] upper_code,
    input wire logic [11:0] lower_code
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    wire hw = ce && host_acc.wr;
    wire lv = ce && link_frame.valid;
    wire timer_frame = lv && link_frame.op == 3'h4 && link_frame.param == 6'h01;
    sequence s_read_taken;
        lv && link_frame.op == 3'h1 && (link_frame.param == my_dev_addr || link_frame.param == 6'h00);
    endsequence
    sequence s_timer_taken;
        timer_frame;
    endsequence
    chk_ref_low_write: assert property (hw && host_acc.addr == 8'h1f
        |=> ref_code[7:0] == $past(host_acc.wdata))
        else $error("reference low byte not written");
    chk_upper_high_write: assert property (hw && host_acc.addr == 8'h22
        |=> upper_code[11:8] == $past(host_acc.wdata[3:0]))
        else $error("upper high nibble not written");
    chk_lower_low_write: assert property (hw && host_acc.addr == 8'h23
        |=> lower_code[7:0] == $past(host_acc.wdata))
        else $error("lower low byte not written");
    chk_read_reply_pulse: assert property (s_read_taken |=> link_rvalid)
        else $error("addressed read gave no reply");
    chk_bcast_ref_load: assert property (lv && !hw && link_frame.op == 3'h4 && link_frame.param == 6'h02
        |=> ref_code == $past(link_frame.data[11:0]))
        else $error("broadcast reference load wrong");
    chk_timer_pulse: assert property (s_timer_taken
        |=> timer_wr && timer_wdata == $past(link_frame.data[7:0]))
        else $error("timer write pulse wrong");
    chk_timer_single: assert property (ce && !timer_frame |=> !timer_wr)
        else $error("timer write pulse held too long");
    chk_bcast_byte_write: assert property (lv && !hw && link_frame.op == 3'h5 && link_frame.param == 6'h00
        && link_frame.reg_addr == 7'h21 |=> upper_code[7:0] == $past(link_frame.data[7:0]))
        else $error("broadcast byte write wrong");
    chk_target_mask: assert property (hw && host_acc.addr == 8'h25 && !is_master
        |=> target_param == ($past(host_acc.wdata) & 8'h3f))
        else $error("target register mask wrong");
    chk_cmd_clear: assert property (ce && xact_done && !(hw && host_acc.addr == 8'h28)
        |=> !link_cmd_start && link_cmd_op == 3'h0)
        else $error("command register not cleared");
endmodule : ctdb_regs_chk
bind ctdb_regs ctdb_regs_chk i_ctdb_regs_chk (.clk(clk), .rst_n(rst_n), .ce(ce), .is_master(is_master),
    .my_dev_addr(my_dev_addr), .host_acc(host_acc), .link_frame(link_frame), .xact_done(xact_done),
    .target_param(target_param), .link_cmd_start(link_cmd_start), .link_cmd_op(link_cmd_op),
    .link_rvalid(link_rvalid), .timer_wr(timer_wr), .timer_wdata(timer_wdata), .ref_code(ref_code),
    .upper_code(upper_code), .lower_code(lower_code));
`default_nettype wire

//--- test/ctdb_host_model.sv
// Host controller model that issues one-cycle register strobes.
`timescale 1ns/1ps
`default_nettype none
module ctdb_host_model (
    input wire logic clk,
    output ctdb_pkg::ctdb_access_t host_acc,
    input wire logic [7:0] host_rdata
);
    initial host_acc = '0;
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        host_acc <= '{1'b1, 1'b0, a, d};
        @(posedge clk);
        host_acc <= '{1'b0, 1'b0, ~a, ~d};
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk);
        host_acc <= '{1'b0, 1'b1, a, 8'h00};
        @(posedge clk);
        host_acc <= '{1'b0, 1'b0, ~a, 8'hff};
        #1 d = host_rdata;
    endtask : rd
endmodule : ctdb_host_model
`default_nettype wire

//--- test/ctdb_regs_test.sv
// Self-checking bench for the threshold register group.
`timescale 1ns/1ps
`default_nettype none
module ctdb_regs_test;
    logic clk, rst_n, ce, is_master, xact_done, rv, tw, cs, link_rvalid, timer_wr;
    logic [7:0] rd, host_rdata, link_rdata, target_param, timer_wdata;
    logic [2:0] cop;
    logic [5:0] dev;
    logic [11:0] ref_code, upper_code, lower_code;
    ctdb_pkg::ctdb_access_t host_acc;
    ctdb_pkg::ctdb_frame_t link_frame;
    int fails = 0;
    int compares = 0;
    ctdb_host_model i_ctdb_host_model (.clk(clk), .host_acc(host_acc), .host_rdata(host_rdata));
    ctdb_regs i_ctdb_regs (.clk(clk), .rst_n(rst_n), .ce(ce), .is_master(is_master), .my_dev_addr(dev),
        .host_acc(host_acc), .host_rdata(host_rdata), .link_frame(link_frame), .link_rdata(link_rdata),
        .link_rvalid(link_rvalid), .xact_done(xact_done), .target_param(target_param), .link_cmd_start(cs),
        .link_cmd_op(cop), .timer_wr(timer_wr), .timer_wdata(timer_wdata), .ref_code(ref_code),
        .upper_code(upper_code), .lower_code(lower_code));
    task automatic chk(input logic [15:0] s, input logic [15:0] e);
        compares++;
        if (s !== e)
        begin
            fails++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask : chk
    task automatic final_report();
        if (fails == 0 && compares > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : final_report
    task automatic lk(input logic [2:0] op, input logic [5:0] p, input logic [6:0] ra, input logic [15:0] d);
        @(posedge clk);
        link_frame <= '{1'b1, op, p, ra, d};
        @(posedge clk);
        link_frame <= '{1'b0, ~op, ~p, ~ra, ~d};
        #1 rv = link_rvalid;
        tw = timer_wr;
    endtask : lk
    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    initial
    begin
        #200000;
        fails++;
        final_report();
    end
    initial
    begin
        rst_n = 1'b0;
        ce = 1'b1;
        is_master = 1'b0;
        xact_done = 1'b0;
        dev = 6'h0b;
        link_frame = '0;
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        for (int a = 8'h1f; a <= 8'h28; a++)
        begin
            i_ctdb_host_model.rd(8'(a), rd);
            chk(rd, 16'h0000);
            i_ctdb_host_model.wr(8'(a), 8'hff);
        end
        i_ctdb_host_model.wr(8'h30, 8'hff);
        for (int a = 8'h1f; a <= 8'h25; a++)
        begin
            i_ctdb_host_model.rd(8'(a), rd);
            chk(rd, (a == 8'h25) ? 8'h3f : ((a[0] == 1'b0) ? 8'h0f : 8'hff));
        end
        i_ctdb_host_model.rd(8'h30, rd);
        chk(rd, 16'h0000);
        chk({ref_code, 4'h0}, 16'hfff0);
        chk({upper_code, lower_code[11:8]}, 16'hffff);
        is_master <= 1'b1;
        i_ctdb_host_model.wr(8'h25, 8'hc1);
        i_ctdb_host_model.rd(8'h25, rd);
        chk(rd, 16'h00c1);
        chk(target_param, 16'h00c1);
        lk(3'h4, 6'h02, 7'h00, 16'h0123);
        lk(3'h4, 6'h04, 7'h00, 16'h0456);
        lk(3'h4, 6'h03, 7'h00, 16'h0789);
        chk(ref_code, 16'h0123);
        chk(upper_code, 16'h0456);
        chk(lower_code, 16'h0789);
        lk(3'h4, 6'h01, 7'h00, 16'h00a5);
        chk({tw, timer_wdata}, 16'h01a5);
        lk(3'h4, 6'h00, 7'h00, 16'h0bbb);
        chk({tw, ref_code}, 16'h0123);
        lk(3'h1, 6'h0b, 7'h21, 16'h0000);
        chk({rv, link_rdata}, 16'h0156);
        lk(3'h1, 6'h0c, 7'h21, 16'h0000);
        chk(rv, 16'h0000);
        lk(3'h2, 6'h00, 7'h24, 16'h0003);
        chk(lower_code, 16'h0389);
        lk(3'h2, 6'h00, 7'h25, 16'h0055);
        i_ctdb_host_model.rd(8'h25, rd);
        chk(rd, 16'h00c1);
        lk(3'h5, 6'h00, 7'h21, 16'h005a);
        chk(upper_code, 16'h045a);
        dev <= 6'h0c;
        lk(3'h1, 6'h0c, 7'h21, 16'h0000);
        chk({rv, link_rdata}, 16'h015a);
        i_ctdb_host_model.wr(8'h28, 8'hf5);
        i_ctdb_host_model.rd(8'h28, rd);
        chk({cs, cop, rd}, 16'h0a05);
        xact_done <= 1'b1;
        @(posedge clk);
        xact_done <= 1'b0;
        #1 chk({cs, cop}, 16'h0000);
        i_ctdb_host_model.wr(8'h28, 8'h03);
        @(posedge clk);
        ce <= 1'b0;
        xact_done <= 1'b1;
        i_ctdb_host_model.wr(8'h1f, 8'h11);
        #1 chk({cs, cop, ref_code}, 16'h9123);
        ce <= 1'b1;
        xact_done <= 1'b0;
        final_report();
    end
endmodule : ctdb_regs_test
`default_nettype wire
